// file: fmcs_map.vh
// Constants of the fan motor control supervisor
`ifndef FMCS_MAP_VH
`define FMCS_MAP_VH
// Readback register offsets
`define FMCS_FAULT_READBACK_PRIMARY 8'h93
`define FMCS_SYNC_LOSS_READBACK 8'h94
// Fault readback field positions
`define FMCS_BIT_VDS_LO 0
`define FMCS_BIT_TSD 6
`define FMCS_BIT_CP_UV 7
`define FMCS_BIT_VBB_UV 8
`define FMCS_BIT_VBB_OV 9
`define FMCS_RB_RESET 16'h0000
// Timing: coast and lock off-time defaults, in ms and cycles at 25 MHz
`define FMCS_CLK_HZ 25000000
`define FMCS_LOCK_OFF_MS 500
`define FMCS_COAST_MS 100
`define FMCS_LOCK_OFF_CYC ((`FMCS_CLK_HZ / 1000) * `FMCS_LOCK_OFF_MS)
`define FMCS_COAST_CYC ((`FMCS_CLK_HZ / 1000) * `FMCS_COAST_MS)
// PWM duty measurement window: 10 ms covers a full period down to 100 Hz
`define FMCS_DUTY_WIN_CYC 250000
`define FMCS_DEMAND_W 9
`define FMCS_START_CYC 25000
`endif

// file: fmcs_phase_gen.v
// One motor phase: sine-like modulation compare from a phase angle
`timescale 1ns/1ns
module fmcs_phase_gen #(
  parameter [9:0] OFFSET = 10'h000
)(
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Drive inputs
  input wire [9:0] angle,
  input wire [8:0] demand,
  input wire [8:0] carrier,
  // Phase output
  output reg phase_pwm_q
);
  wire [9:0] ang;
  wire [8:0] tri_val;
  wire [17:0] prod;
  assign ang = angle + OFFSET;
  // Triangle approximation of a sine, folded about mid-scale
  assign tri_val = ang[9] ? (9'h1FF - ang[8:0]) : ang[8:0];
  assign prod = tri_val * demand;
  always @(posedge core_clk)
  begin
    if (!rst_b)
      phase_pwm_q <= 1'b0;
    else
      phase_pwm_q <= (prod[17:9] > carrier);
  end
endmodule // fmcs_phase_gen

// file: fmcs_supervisor.v
// Control and supervision logic of a three-phase sinusoidal fan driver
// Functional notes
// - PWM mode: measure duty into 9-bit demand
// - Modulate three phases spaced 120 degrees
// - Config bit selects analog or PWM input
// - Analog mode: 9-bit converter, higher is faster
// - Standby after input low past lock time
// - Standby disable bit; no standby if nonstop
// - Wake straight into active at power-up
// - Rotor-fault output high on rotor fault
// - If disabled, rising edge marks start end
// - Brake turns all low sides on
// - Brake overrides demand and blocks standby
// - Direction high ABC, low ACB
// - Direction change: coast, then restart
// - Open gate-current pin disables outputs
// - Lock fault: off for lock time, restart
// - Fault output low on six conditions
// - UV, thermal, CP UV: disable, unlatched, readback
// - Overvoltage: disable, optional lock, unlatched
// - Drain-source fault action selectable, may latch
// - Sync loss starts lock timeout, readback
// - Lock off-time within 4 percent
`timescale 1ns/1ns
`include "fmcs_map.vh"
module fmcs_supervisor #(
  parameter [31:0] LOCK_OFF_CYC = `FMCS_LOCK_OFF_CYC,
  parameter [31:0] COAST_CYC = `FMCS_COAST_CYC,
  parameter [31:0] DUTY_WIN_CYC = `FMCS_DUTY_WIN_CYC,
  parameter [31:0] START_CYC = `FMCS_START_CYC
)(
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Speed demand
  input wire speed_demand_in,
  input wire [8:0] adc_code,
  // Motor controls
  input wire brake_in,
  input wire dir_in,
  input wire gate_current_set_pin_open,
  input wire rotor_position_ok,
  // Protection monitors
  input wire vbb_uv,
  input wire thermal_shutdown,
  input wire cp_uv,
  input wire vbb_ov,
  input wire [5:0] vds_fault,
  input wire [6:0] sync_loss,
  // Nonvolatile configuration and rotor fault condition
  input wire cfg_analog_mode,
  input wire cfg_standby_dis,
  input wire cfg_nonstop_curve,
  input wire cfg_rotor_fault_en,
  input wire cfg_ov_sets_lock,
  input wire overcurrent_action_sel,
  input wire rotor_fault_cond,
  // Register readback
  input wire [7:0] rb_addr,
  output reg [15:0] rb_data_q,
  // Motor drive
  output wire [2:0] high_side_on,
  output wire [2:0] low_side_on,
  output reg [8:0] demand_q,
  output reg standby_q,
  output reg fault_out_n_q,
  output reg rotor_fault_q
);
  // ****************************************
  // State encoding
  // ****************************************
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_COAST = 3'h1;
  localparam [2:0] ST_LOCKOFF = 3'h2;
  localparam [2:0] ST_STANDBY = 3'h3;
  localparam [2:0] ST_START = 3'h4;

  reg [2:0] state_q;
  reg [31:0] tmr_q;
  reg [31:0] win_q;
  reg [31:0] high_cnt_q;
  reg [31:0] low_cnt_q;
  reg [8:0] pwm_demand_q;
  reg [5:0] vds_latch_q;
  reg dir_q;
  reg [9:0] angle_q;
  reg [8:0] carrier_q;
  wire [2:0] pwm;
  wire [5:0] vds_eff;
  wire hard_off;
  wire lock_trig;
  wire any_fault;
  wire [31:0] duty_prod;
  wire [31:0] duty_quot;
  wire standby_ok;

  // ****************************************
  // Demand capture
  // ****************************************
  // Duty = high samples scaled to 511 over a fixed window
  assign duty_prod = high_cnt_q * 32'd511;
  assign duty_quot = duty_prod / DUTY_WIN_CYC;
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      win_q <= 32'h0;
      high_cnt_q <= 32'h0;
      pwm_demand_q <= 9'h000;
    end
    else if (win_q >= DUTY_WIN_CYC - 32'd1)
    begin
      win_q <= 32'h0;
      high_cnt_q <= 32'h0;
      pwm_demand_q <= (duty_quot > 32'd511) ? 9'h1FF : duty_quot[8:0];
    end
    else
    begin
      win_q <= win_q + 32'd1;
      high_cnt_q <= high_cnt_q + {31'h0, speed_demand_in};
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
      demand_q <= 9'h000;
    else if (brake_in)
      demand_q <= 9'h000;
    else if (cfg_analog_mode)
      demand_q <= adc_code;
    else
      demand_q <= pwm_demand_q;
  end

  // ****************************************
  // Fault gathering
  // ****************************************
  always @(posedge core_clk)
  begin
    if (!rst_b)
      vds_latch_q <= 6'h00;
    else if (overcurrent_action_sel)
      vds_latch_q <= vds_latch_q | vds_fault;
    else
      vds_latch_q <= 6'h00;
  end
  assign vds_eff = vds_fault | vds_latch_q;
  assign hard_off = vbb_uv | thermal_shutdown | cp_uv | vbb_ov | (|vds_eff) |
    gate_current_set_pin_open;
  assign lock_trig = (|sync_loss) | (vbb_ov & cfg_ov_sets_lock) |
    !rotor_position_ok;
  assign any_fault = vbb_uv | thermal_shutdown | cp_uv | vbb_ov | (|vds_eff) |
    (|sync_loss);

  always @(posedge core_clk)
  begin
    if (!rst_b)
      fault_out_n_q <= 1'b1;
    else
      fault_out_n_q <= !any_fault;
  end

  // ****************************************
  // Readback
  // ****************************************
  always @(posedge core_clk)
  begin
    if (!rst_b)
      rb_data_q <= `FMCS_RB_RESET;
    else if (rb_addr == `FMCS_FAULT_READBACK_PRIMARY)
      rb_data_q <= {6'h00, vbb_ov, vbb_uv, cp_uv, thermal_shutdown, vds_eff};
    else if (rb_addr == `FMCS_SYNC_LOSS_READBACK)
      rb_data_q <= {9'h000, sync_loss};
    else
      rb_data_q <= 16'h0000;
  end

  // ****************************************
  // Run control
  // ****************************************
  assign standby_ok = !cfg_standby_dis && !cfg_nonstop_curve && !brake_in;
  always @(posedge core_clk)
  begin
    if (!rst_b)
      low_cnt_q <= 32'h0;
    else if (speed_demand_in || !standby_ok)
      low_cnt_q <= 32'h0;
    else if (low_cnt_q < LOCK_OFF_CYC)
      low_cnt_q <= low_cnt_q + 32'd1;
  end

  // Reset lands in START, never in STANDBY
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_q <= ST_START;
      tmr_q <= 32'h0;
      dir_q <= 1'b1;
      standby_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_START, ST_RUN:
        begin
          // Blocking conditions gate entry too, the count lags them by one cycle
          if (low_cnt_q >= LOCK_OFF_CYC && standby_ok)
          begin
            state_q <= ST_STANDBY;
            standby_q <= 1'b1;
          end
          else if (dir_in != dir_q)
          begin
            state_q <= ST_COAST;
            tmr_q <= 32'h0;
          end
          else if (lock_trig && !brake_in)
          begin
            state_q <= ST_LOCKOFF;
            tmr_q <= 32'h0;
          end
          else if (state_q == ST_START)
          begin
            if (tmr_q >= START_CYC - 32'd1)
              state_q <= ST_RUN;
            else
              tmr_q <= tmr_q + 32'd1;
          end
        end
        ST_COAST:
        begin
          if (tmr_q >= COAST_CYC - 32'd1)
          begin
            dir_q <= dir_in;
            state_q <= ST_START;
            tmr_q <= 32'h0;
          end
          else
            tmr_q <= tmr_q + 32'd1;
        end
        ST_LOCKOFF:
        begin
          // Exact cycle count, well inside the allowed tolerance
          if (tmr_q >= LOCK_OFF_CYC - 32'd1)
          begin
            state_q <= ST_START;
            tmr_q <= 32'h0;
          end
          else
            tmr_q <= tmr_q + 32'd1;
        end
        ST_STANDBY:
        begin
          if (speed_demand_in || !standby_ok)
          begin
            standby_q <= 1'b0;
            state_q <= ST_START;
            tmr_q <= 32'h0;
          end
        end
        default:
          state_q <= ST_START;
      endcase
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
      rotor_fault_q <= 1'b0;
    else if (cfg_rotor_fault_en)
      rotor_fault_q <= rotor_fault_cond;
    else
      rotor_fault_q <= (state_q == ST_RUN);
  end

  // ****************************************
  // Modulation
  // ****************************************
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      angle_q <= 10'h000;
      carrier_q <= 9'h000;
    end
    else
    begin
      carrier_q <= carrier_q + 9'h001;
      if (carrier_q == 9'h1FF)
        angle_q <= dir_q ? angle_q + 10'h001 : angle_q - 10'h001;
    end
  end

  // Offsets of one and two thirds of a turn
  fmcs_phase_gen #(.OFFSET(10'h000)) u_pa (.core_clk(core_clk), .rst_b(rst_b),
    .angle(angle_q), .demand(demand_q), .carrier(carrier_q), .phase_pwm_q(pwm[0]));
  fmcs_phase_gen #(.OFFSET(10'h2AB)) u_pb (.core_clk(core_clk), .rst_b(rst_b),
    .angle(angle_q), .demand(demand_q), .carrier(carrier_q), .phase_pwm_q(pwm[1]));
  fmcs_phase_gen #(.OFFSET(10'h155)) u_pc (.core_clk(core_clk), .rst_b(rst_b),
    .angle(angle_q), .demand(demand_q), .carrier(carrier_q), .phase_pwm_q(pwm[2]));

  wire drive_ok;
  assign drive_ok = !hard_off && (state_q == ST_RUN || state_q == ST_START);
  assign high_side_on = (drive_ok && !brake_in) ? pwm : 3'h0;
  assign low_side_on = brake_in && !hard_off ? 3'h7 :
    (drive_ok ? ~pwm : 3'h0);
endmodule // fmcs_supervisor

// file: fmcs_supervisor_sva.sv
// Port checker of the fan motor control supervisor
`timescale 1ns/1ns
module fmcs_sup_chk #(
  parameter [31:0] LOCK_OFF_CYC = 32'd200
)(
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Controls
  input wire speed_demand_in,
  input wire brake_in,
  input wire gate_current_set_pin_open,
  input wire cfg_standby_dis,
  input wire overcurrent_action_sel,
  // Monitors
  input wire vbb_uv,
  input wire thermal_shutdown,
  input wire cp_uv,
  input wire vbb_ov,
  input wire [5:0] vds_fault,
  input wire [6:0] sync_loss,
  // Readback address and outputs
  input wire [7:0] rb_addr,
  input wire [15:0] rb_data_q,
  input wire [2:0] high_side_on,
  input wire [2:0] low_side_on,
  input wire standby_q,
  input wire fault_out_n_q
);
  wire any_f = vbb_uv | thermal_shutdown | cp_uv | vbb_ov | (|vds_fault) | (|sync_loss);
  wire off_f = vbb_uv | thermal_shutdown | cp_uv;
  reg [31:0] lo_q;
  // Counts every low cycle, so the design's own count can never exceed it
  always @(posedge core_clk)
    lo_q <= (!rst_b || speed_demand_in) ? 32'h0 : lo_q + 32'h1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_brake2;
    (brake_in && !any_f && !gate_current_set_pin_open)[*2];
  endsequence
  // A latched drain-source fault lingers one cycle after its select drops
  sequence s_clear2;
    (!any_f && !overcurrent_action_sel)[*2];
  endsequence
  sequence s_off2;
    (off_f && !brake_in)[*2];
  endsequence
  chk_fault_low: assert property (any_f |=> !fault_out_n_q)
    else $error("fault output not low");
  chk_fault_high: assert property (s_clear2 |=> fault_out_n_q)
    else $error("fault output not released");
  chk_rb_top: assert property (rb_addr == 8'h93 |=> rb_data_q[15:10] == 6'h00)
    else $error("primary readback upper bits set");
  chk_rb_sync: assert property (rb_addr == 8'h94 |=> rb_data_q[15:7] == 9'h000)
    else $error("sync readback upper bits set");
  chk_rb_none: assert property (!(rb_addr inside {8'h93, 8'h94}) |=> rb_data_q == 16'h0000)
    else $error("unmapped readback not zero");
  chk_brake_low: assert property (s_brake2 |-> low_side_on == 3'h7 && high_side_on == 3'h0)
    else $error("brake drive wrong");
  chk_gate_off: assert property (gate_current_set_pin_open [*2] |-> !(|{high_side_on, low_side_on}))
    else $error("outputs on with open pin");
  chk_uv_off: assert property (s_off2 |-> (high_side_on | low_side_on) == 3'h0)
    else $error("outputs on during fault");
  chk_stby_block: assert property ((brake_in || cfg_standby_dis) && !standby_q |=> !standby_q)
    else $error("standby entered while blocked");
  chk_stby_time: assert property ($rose(standby_q) |-> (lo_q + 32'd2) * 25 >= LOCK_OFF_CYC * 24)
    else $error("standby entered early");
endmodule // fmcs_sup_chk

// file: fmcs_bridge_model.sv
// Behavioural external bridge and fan motor
`timescale 1ns/1ns
module fmcs_bridge_model (
  // Clock
  input wire core_clk,
  // Gate commands
  input wire [2:0] high_side_on,
  input wire [2:0] low_side_on,
  // Motor
  input wire stall,
  output reg [2:0] phase_v,
  output wire rotor_position_ok,
  output reg shoot_seen
);
  initial phase_v = 3'h0;
  initial shoot_seen = 1'b0;
  // A released phase floats, so it shows the inverse of its last level
  always @(posedge core_clk)
  begin
    phase_v <= (high_side_on & ~low_side_on) | (~(high_side_on | low_side_on) & ~phase_v);
    if ((high_side_on & low_side_on) != 3'h0)
      shoot_seen <= 1'b1;
  end
  assign rotor_position_ok = !stall;
endmodule // fmcs_bridge_model

// file: tb_fmcs_supervisor.sv
// Self-checking bench of the fan motor control supervisor
`timescale 1ns/1ns
module tb_fmcs_supervisor;
  localparam [31:0] LOCK = 32'd200;
  localparam [31:0] WIN = 32'd1000;
  reg core_clk = 1'b0, rst_b = 1'b0, speed_demand_in = 1'b1, brake_in = 1'b0, dir_in = 1'b1;
  reg gate_current_set_pin_open = 1'b0, vbb_uv = 1'b0, thermal_shutdown = 1'b0, cp_uv = 1'b0;
  reg vbb_ov = 1'b0, cfg_analog_mode = 1'b0, cfg_standby_dis = 1'b0, cfg_nonstop_curve = 1'b0;
  reg cfg_rotor_fault_en = 1'b0, cfg_ov_sets_lock = 1'b0, overcurrent_action_sel = 1'b0;
  reg rotor_fault_cond = 1'b0, stall = 1'b0;
  reg [5:0] vds_fault = 6'h00;
  reg [6:0] sync_loss = 7'h00;
  reg [8:0] adc_code = 9'h000;
  reg [8:0] d_lo;
  reg [7:0] rb_addr = 8'h00;
  reg [25:0] rows [0:6];
  wire [15:0] rb_data_q;
  wire [2:0] high_side_on, low_side_on, phase_v;
  wire [8:0] demand_q;
  wire standby_q, fault_out_n_q, rotor_fault_q, rotor_position_ok, shoot_seen;
  integer err_total = 0, n_compared = 0, i;
  always #20 core_clk = ~core_clk;
  fmcs_supervisor #(.LOCK_OFF_CYC(LOCK), .COAST_CYC(32'd100), .DUTY_WIN_CYC(WIN),
    .START_CYC(32'd100)) i_fmcs_supervisor (.core_clk, .rst_b, .speed_demand_in, .adc_code,
    .brake_in, .dir_in, .gate_current_set_pin_open, .rotor_position_ok, .vbb_uv,
    .thermal_shutdown, .cp_uv, .vbb_ov, .vds_fault, .sync_loss, .cfg_analog_mode,
    .cfg_standby_dis, .cfg_nonstop_curve, .cfg_rotor_fault_en, .cfg_ov_sets_lock,
    .overcurrent_action_sel, .rotor_fault_cond, .rb_addr, .rb_data_q, .high_side_on,
    .low_side_on, .demand_q, .standby_q, .fault_out_n_q, .rotor_fault_q);
  fmcs_bridge_model i_fmcs_bridge_model (.core_clk, .high_side_on, .low_side_on, .stall,
    .phase_v, .rotor_position_ok, .shoot_seen);
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task report_and_stop;
  begin
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  task rd(input [7:0] a);
  begin
    rb_addr = a;
    cyc(2);
  end
  endtask
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    // Fault inputs {ov, uv, cp, tsd, vds} beside the readback they give
    rows[0] = {10'h200, 16'h0200};
    rows[1] = {10'h100, 16'h0100};
    rows[2] = {10'h080, 16'h0080};
    rows[3] = {10'h040, 16'h0040};
    rows[4] = {10'h03F, 16'h003F};
    rows[5] = {10'h2C1, 16'h02C1};
    rows[6] = {10'h000, 16'h0000};
    cyc(4);
    rst_b = 1'b1;
    cyc(1);
    chk({fault_out_n_q, standby_q, demand_q}, {1'b1, 1'b0, 9'h000});
    for (i = 0; i < 7; i = i + 1)
    begin
      {vbb_ov, vbb_uv, cp_uv, thermal_shutdown, vds_fault} = rows[i][25:16];
      rd(8'h93);
      chk(rb_data_q, rows[i][15:0]);
      chk(fault_out_n_q, rows[i][15:0] == 16'h0000);
    end
    $display("fault table done");
    sync_loss = 7'h55;
    rd(8'h94);
    chk(rb_data_q, 16'h0055);
    chk(fault_out_n_q, 1'b0);
    sync_loss = 7'h00;
    rd(8'h95);
    chk({fault_out_n_q, rb_data_q[14:0]}, 16'h8000);
    overcurrent_action_sel = 1'b1;
    vds_fault = 6'h04;
    cyc(2);
    vds_fault = 6'h00;
    cyc(3);
    chk(fault_out_n_q, 1'b0);
    overcurrent_action_sel = 1'b0;
    cyc(2);
    chk(fault_out_n_q, 1'b1);
    brake_in = 1'b1;
    cyc(3);
    chk(low_side_on, 3'h7);
    brake_in = 1'b0;
    gate_current_set_pin_open = 1'b1;
    cyc(3);
    chk({high_side_on, low_side_on}, 6'h00);
    gate_current_set_pin_open = 1'b0;
    $display("fault and drive tests done");
    // Half duty at 100 kHz, within the allowed input rate; direction flips midway
    fork
      repeat (12)
      begin
        speed_demand_in = 1'b1;
        cyc(125);
        speed_demand_in = 1'b0;
        cyc(125);
      end
      begin
        cyc(1500);
        dir_in = 1'b0;
        cyc(3);
        chk({rotor_fault_q, high_side_on, low_side_on}, 7'h00);
        // Coast of 100 cycles, then a start of 100 cycles, then run
        cyc(204);
        chk({rotor_fault_q, high_side_on | low_side_on}, 4'hF);
      end
    join
    chk(demand_q >= 9'h0FB && demand_q <= 9'h104, 1'b1);
    speed_demand_in = 1'b1;
    chk(rotor_fault_q, 1'b1);
    cfg_rotor_fault_en = 1'b1;
    rotor_fault_cond = 1'b1;
    cyc(2);
    chk(rotor_fault_q, 1'b1);
    rotor_fault_cond = 1'b0;
    cyc(2);
    chk(rotor_fault_q, 1'b0);
    cfg_rotor_fault_en = 1'b0;
    stall = 1'b1;
    cyc(2);
    chk({high_side_on, low_side_on}, 6'h00);
    stall = 1'b0;
    cyc(LOCK - 4);
    chk({high_side_on, low_side_on}, 6'h00);
    cyc(8);
    chk(high_side_on | low_side_on, 3'h7);
    $display("rotor and lock tests done");
    cfg_analog_mode = 1'b1;
    adc_code = 9'h080;
    cyc(WIN + 20);
    d_lo = demand_q;
    adc_code = 9'h180;
    cyc(WIN + 20);
    chk(demand_q > d_lo, 1'b1);
    cfg_analog_mode = 1'b0;
    $display("demand tests done");
    for (i = 0; i < 4; i = i + 1)
    begin
      {cfg_standby_dis, cfg_nonstop_curve, brake_in} = 3'b100 >> i;
      speed_demand_in = 1'b0;
      cyc(LOCK * 24 / 25 - 4);
      chk(standby_q, 1'b0);
      cyc(LOCK / 10 + 8);
      chk(standby_q, i == 3);
      speed_demand_in = 1'b1;
      cyc(2);
    end
    // Reset taken in standby must come back awake
    speed_demand_in = 1'b0;
    cyc(LOCK + 4);
    chk(standby_q, 1'b1);
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    cyc(1);
    chk({fault_out_n_q, standby_q, rotor_fault_q, demand_q}, 12'h800);
    speed_demand_in = 1'b1;
    cyc(2);
    chk(shoot_seen, 1'b0);
    $display("standby tests done");
    report_and_stop;
  end
  initial
  begin
    cyc(20000);
    err_total = err_total + 1;
    report_and_stop;
  end
endmodule // tb_fmcs_supervisor
bind fmcs_supervisor fmcs_sup_chk #(.LOCK_OFF_CYC(LOCK_OFF_CYC)) i_fmcs_sup_chk (.core_clk,
  .rst_b, .speed_demand_in, .brake_in, .gate_current_set_pin_open, .cfg_standby_dis,
  .overcurrent_action_sel, .vbb_uv, .thermal_shutdown, .cp_uv, .vbb_ov, .vds_fault,
  .sync_loss, .rb_addr, .rb_data_q, .high_side_on, .low_side_on, .standby_q, .fault_out_n_q);
